// [src/ebc_ready_pkg.sv]
package ebc_ready_pkg;
    // Bus reference clock timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCS_NS = 20;
    localparam int TCS_CYCLES = (TCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCS_HALF = (TCS_CYCLES + 1) / 2;
    localparam int DIV_W = 4;

    // Bus widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;

    // Phase length fields, in reference clock periods
    localparam int AB_W = 3;
    localparam int C_W = 2;
    localparam int D_W = 1;
    localparam int E_W = 6;
    localparam int F_W = 2;
    localparam int CNT_W = 6;
    localparam int WAIT_W = 8;

    // Ready synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Values after reset
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 6'h00;
    localparam logic [WAIT_W-1:0] WAIT_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h0;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_DSETUP,
        PH_ACCESS,
        PH_RDYWAIT,
        PH_HOLD
    } phase_t;
endpackage : ebc_ready_pkg

// [src/ready_sampler.sv]
`timescale 1ns/100ps
`default_nettype none
module ready_sampler #(
    parameter int STAGES = ebc_ready_pkg::SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ready_pin,
    input wire logic active_high,
    input wire logic async_mode,
    output logic ready_seen
);
    logic [STAGES-1:0] sync_ff;
    logic level;

    // Two-stage chain for the asynchronous mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= {sync_ff[STAGES-2:0], ready_pin};
        end
    end

    // Synchronous mode reads the pin directly
    assign level = async_mode ? sync_ff[STAGES-1] : ready_pin;
    assign ready_seen = active_high ? level : ~level;

    a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
        async_mode && $stable(async_mode) && $stable(active_high)
        && $past(rst_n, 2)
        |-> ready_seen == (active_high ? $past(ready_pin, 2)
                                       : !$past(ready_pin, 2)))
        else $error("async ready not delayed by two stages");
endmodule : ready_sampler
`default_nettype wire

// [src/external_bus_ready_waitstate.sv]
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - External circuit stretches or ends each bus cycle through the ready input.
// - Ready active level is selectable, high or low.
// - Synchronous mode samples ready directly; ready must follow the reference clock.
// - Asynchronous mode adds a two-stage synchroniser, costing at least one wait state.
// - Ready seen inactive inserts one wait state, then samples again.
// - Ready seen active ends the command and enters closing phases.
// - Ready ignored until mandatory access phase wait states elapse.
// - Read data captured on the edge that raises the read strobe.
module external_bus_ready_waitstate #(
    parameter int ADDR_W = ebc_ready_pkg::ADDR_W,
    parameter int DATA_W = ebc_ready_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic rst_n,
    // Request side
    input wire logic start,
    input wire logic write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ebc_ready_pkg::AB_W-1:0] addr_phase_length,
    input wire logic [ebc_ready_pkg::C_W-1:0] cmd_phase_length,
    input wire logic [ebc_ready_pkg::D_W-1:0] setup_phase_length,
    input wire logic [ebc_ready_pkg::E_W-1:0] access_phase_length,
    input wire logic [ebc_ready_pkg::F_W-1:0] hold_phase_length,
    input wire logic ready_enable,
    input wire logic ready_active_high,
    input wire logic ready_async,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic [ebc_ready_pkg::WAIT_W-1:0] wait_states,
    // Bus pins
    output logic bus_reference_clock_output,
    output logic [ADDR_W-1:0] bus_addr,
    output logic rd_n,
    output logic wr_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic ready_in
);
    localparam logic [ebc_ready_pkg::DIV_W-1:0] TICK_AT =
        ebc_ready_pkg::DIV_W'(ebc_ready_pkg::TCS_CYCLES - 1);
    localparam logic [ebc_ready_pkg::DIV_W-1:0] FALL_AT =
        ebc_ready_pkg::DIV_W'(ebc_ready_pkg::TCS_HALF - 1);
    logic [ebc_ready_pkg::DIV_W-1:0] div_ff;
    logic tick;
    logic bus_reference_clock_output_ff;
    ebc_ready_pkg::phase_t phase_ff, nxt_phase;
    logic [ebc_ready_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic pend_ff, wr_ff, rdy_en_ff, async_ff, pol_ff;
    logic [ADDR_W-1:0] addr_ff, bus_addr_ff;
    logic [DATA_W-1:0] wdata_ff, data_out_ff, rdata_ff;
    logic [ebc_ready_pkg::AB_W-1:0] len_ab_ff;
    logic [ebc_ready_pkg::C_W-1:0] len_c_ff;
    logic [ebc_ready_pkg::D_W-1:0] len_d_ff;
    logic [ebc_ready_pkg::E_W-1:0] len_e_ff;
    logic [ebc_ready_pkg::F_W-1:0] len_f_ff;
    logic [ebc_ready_pkg::WAIT_W-1:0] wait_ff;
    logic rd_n_ff, wr_n_ff, oe_ff, done_ff;
    logic ready_seen, last, cmd_end, take;

    // Length of a phase in reference clock periods
    function automatic logic [ebc_ready_pkg::CNT_W-1:0] phase_len(
        input ebc_ready_pkg::phase_t ph,
        input logic [ebc_ready_pkg::AB_W-1:0] ab,
        input logic [ebc_ready_pkg::C_W-1:0] c,
        input logic [ebc_ready_pkg::D_W-1:0] d,
        input logic [ebc_ready_pkg::E_W-1:0] e,
        input logic [ebc_ready_pkg::F_W-1:0] f);
        logic [ebc_ready_pkg::CNT_W-1:0] len;
        len = ebc_ready_pkg::CNT_RST;
        unique case (ph)
            ebc_ready_pkg::PH_ADDR: len = (ab == 0) ? 6'h01 : 6'(ab);
            ebc_ready_pkg::PH_CMD: len = 6'(c);
            ebc_ready_pkg::PH_DSETUP: len = 6'(d);
            ebc_ready_pkg::PH_ACCESS: len = (e == 0) ? 6'h01 : e;
            ebc_ready_pkg::PH_HOLD: len = 6'(f);
            ebc_ready_pkg::PH_RDYWAIT: len = 6'h01;
            ebc_ready_pkg::PH_IDLE: len = ebc_ready_pkg::CNT_RST;
        endcase
        return len;
    endfunction : phase_len

    // Following phase in the fixed order, skipping empty ones
    function automatic ebc_ready_pkg::phase_t next_after(
        input ebc_ready_pkg::phase_t ph,
        input logic [ebc_ready_pkg::C_W-1:0] c,
        input logic [ebc_ready_pkg::D_W-1:0] d,
        input logic [ebc_ready_pkg::F_W-1:0] f);
        ebc_ready_pkg::phase_t n;
        n = ebc_ready_pkg::PH_IDLE;
        unique case (ph)
            ebc_ready_pkg::PH_IDLE: n = ebc_ready_pkg::PH_ADDR;
            ebc_ready_pkg::PH_ADDR: n = (c != 0) ? ebc_ready_pkg::PH_CMD :
                (d != 0) ? ebc_ready_pkg::PH_DSETUP : ebc_ready_pkg::PH_ACCESS;
            ebc_ready_pkg::PH_CMD: n = (d != 0) ? ebc_ready_pkg::PH_DSETUP :
                ebc_ready_pkg::PH_ACCESS;
            ebc_ready_pkg::PH_DSETUP: n = ebc_ready_pkg::PH_ACCESS;
            ebc_ready_pkg::PH_ACCESS, ebc_ready_pkg::PH_RDYWAIT: n =
                (f != 0) ? ebc_ready_pkg::PH_HOLD : ebc_ready_pkg::PH_IDLE;
            ebc_ready_pkg::PH_HOLD: n = ebc_ready_pkg::PH_IDLE;
        endcase
        return n;
    endfunction : next_after

    ready_sampler #(.STAGES(ebc_ready_pkg::SYNC_STAGES)) u_sampler (
        .clk(clk),
        .rst_n(rst_n),
        .ready_pin(ready_in),
        .active_high(pol_ff),
        .async_mode(async_ff),
        .ready_seen(ready_seen)
    );

    // Reference clock divider; tick marks each rising edge
    assign tick = (div_ff == TICK_AT);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= ebc_ready_pkg::DIV_RST;
            bus_reference_clock_output_ff <= 1'b0;
        end else begin
            div_ff <= tick ? ebc_ready_pkg::DIV_RST : div_ff + 4'h1;
            if (tick) begin
                bus_reference_clock_output_ff <= 1'b1;
            end else if (div_ff == FALL_AT) begin
                bus_reference_clock_output_ff <= 1'b0;
            end
        end
    end

    // Request capture with configuration held for the cycle
    assign take = start && !busy;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            wr_ff <= 1'b0;
            rdy_en_ff <= 1'b0;
            async_ff <= 1'b0;
            pol_ff <= 1'b1;
            addr_ff <= ebc_ready_pkg::ADDR_RST;
            wdata_ff <= ebc_ready_pkg::DATA_RST;
            len_ab_ff <= '0;
            len_c_ff <= '0;
            len_d_ff <= '0;
            len_e_ff <= '0;
            len_f_ff <= '0;
        end else if (take) begin
            pend_ff <= 1'b1;
            wr_ff <= write;
            rdy_en_ff <= ready_enable;
            async_ff <= ready_async;
            pol_ff <= ready_active_high;
            addr_ff <= addr;
            wdata_ff <= wdata;
            len_ab_ff <= addr_phase_length;
            len_c_ff <= cmd_phase_length;
            len_d_ff <= setup_phase_length;
            len_e_ff <= access_phase_length;
            len_f_ff <= hold_phase_length;
        end else if (tick && phase_ff == ebc_ready_pkg::PH_IDLE) begin
            pend_ff <= 1'b0;
        end
    end

    assign last = (cnt_ff <= 6'h01);
    // Phase sequencing; ready only looked at after the access phase
    always_comb begin
        nxt_phase = phase_ff;
        unique case (phase_ff)
            ebc_ready_pkg::PH_IDLE: begin
                if (pend_ff) begin
                    nxt_phase = ebc_ready_pkg::PH_ADDR;
                end
            end
            ebc_ready_pkg::PH_ACCESS: begin
                if (last) begin
                    if (!rdy_en_ff) begin
                        nxt_phase = next_after(phase_ff, len_c_ff, len_d_ff, len_f_ff);
                    end else if (async_ff || !ready_seen) begin
                        nxt_phase = ebc_ready_pkg::PH_RDYWAIT;
                    end else begin
                        nxt_phase = next_after(phase_ff, len_c_ff, len_d_ff, len_f_ff);
                    end
                end
            end
            ebc_ready_pkg::PH_RDYWAIT: begin
                if (ready_seen) begin
                    nxt_phase = next_after(phase_ff, len_c_ff, len_d_ff, len_f_ff);
                end
            end
            default: begin
                if (last) begin
                    nxt_phase = next_after(phase_ff, len_c_ff, len_d_ff, len_f_ff);
                end
            end
        endcase
        nxt_cnt = (nxt_phase != phase_ff) ?
            phase_len(nxt_phase, len_ab_ff, len_c_ff, len_d_ff, len_e_ff, len_f_ff) :
            (last ? cnt_ff : cnt_ff - 6'h01);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= ebc_ready_pkg::PH_IDLE;
            cnt_ff <= ebc_ready_pkg::CNT_RST;
        end else if (tick) begin
            phase_ff <= nxt_phase;
            cnt_ff <= nxt_cnt;
        end
    end

    // Command strobes, address, write data drive
    assign cmd_end = tick && (phase_ff == ebc_ready_pkg::PH_ACCESS ||
        phase_ff == ebc_ready_pkg::PH_RDYWAIT) &&
        nxt_phase != ebc_ready_pkg::PH_RDYWAIT &&
        nxt_phase != ebc_ready_pkg::PH_ACCESS;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            bus_addr_ff <= ebc_ready_pkg::ADDR_RST;
            data_out_ff <= ebc_ready_pkg::DATA_RST;
        end else if (tick) begin
            rd_n_ff <= !(!wr_ff && (nxt_phase == ebc_ready_pkg::PH_ACCESS ||
                nxt_phase == ebc_ready_pkg::PH_RDYWAIT));
            wr_n_ff <= !(wr_ff && (nxt_phase == ebc_ready_pkg::PH_ACCESS ||
                nxt_phase == ebc_ready_pkg::PH_RDYWAIT));
            oe_ff <= wr_ff && nxt_phase != ebc_ready_pkg::PH_IDLE &&
                nxt_phase != ebc_ready_pkg::PH_ADDR &&
                nxt_phase != ebc_ready_pkg::PH_CMD;
            if (phase_ff == ebc_ready_pkg::PH_IDLE && pend_ff) begin
                bus_addr_ff <= addr_ff;
                data_out_ff <= wdata_ff;
            end
        end
    end

    // Read data taken on the strobe's rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= ebc_ready_pkg::DATA_RST;
        end else if (cmd_end && !wr_ff) begin
            rdata_ff <= data_in;
        end
    end

    // Wait state count of the last cycle and completion pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= ebc_ready_pkg::WAIT_RST;
            done_ff <= 1'b0;
        end else begin
            done_ff <= tick && phase_ff != ebc_ready_pkg::PH_IDLE &&
                nxt_phase == ebc_ready_pkg::PH_IDLE;
            if (tick && phase_ff == ebc_ready_pkg::PH_IDLE && pend_ff) begin
                wait_ff <= ebc_ready_pkg::WAIT_RST;
            end else if (tick && nxt_phase == ebc_ready_pkg::PH_RDYWAIT &&
                wait_ff != 8'hFF) begin
                wait_ff <= wait_ff + 8'h01;
            end
        end
    end

    assign busy = pend_ff || phase_ff != ebc_ready_pkg::PH_IDLE;
    assign done = done_ff;
    assign rdata = rdata_ff;
    assign wait_states = wait_ff;
    assign bus_reference_clock_output = bus_reference_clock_output_ff;
    assign bus_addr = bus_addr_ff;
    assign rd_n = rd_n_ff;
    assign wr_n = wr_n_ff;
    assign data_out = data_out_ff;
    assign data_oe = oe_ff;

    a_cmd_low_wait: assert property (@(posedge clk) disable iff (!rst_n)
        phase_ff == ebc_ready_pkg::PH_RDYWAIT |-> !(rd_n_ff && wr_n_ff))
        else $error("command strobe high during ready wait");
    a_async_min_wait: assert property (@(posedge clk) disable iff (!rst_n)
        tick && phase_ff == ebc_ready_pkg::PH_ACCESS && last && rdy_en_ff
        && async_ff |=> phase_ff == ebc_ready_pkg::PH_RDYWAIT)
        else $error("async ready cycle without wait state");
    a_notrdy_wait: assert property (@(posedge clk) disable iff (!rst_n)
        tick && phase_ff == ebc_ready_pkg::PH_RDYWAIT && !ready_seen
        |=> phase_ff == ebc_ready_pkg::PH_RDYWAIT && !(rd_n_ff && wr_n_ff))
        else $error("inactive ready did not add a wait state");
    a_rdy_ends: assert property (@(posedge clk) disable iff (!rst_n)
        tick && phase_ff == ebc_ready_pkg::PH_RDYWAIT && ready_seen
        |=> phase_ff != ebc_ready_pkg::PH_RDYWAIT && rd_n_ff && wr_n_ff)
        else $error("active ready did not end the command");
    a_ignore_early: assert property (@(posedge clk) disable iff (!rst_n)
        tick && phase_ff == ebc_ready_pkg::PH_ACCESS && cnt_ff > 6'h01
        |=> phase_ff == ebc_ready_pkg::PH_ACCESS && cnt_ff == $past(cnt_ff) - 6'h01)
        else $error("access phase cut short");
    a_read_capture: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_end && !wr_ff |=> rdata_ff == $past(data_in) && rd_n_ff)
        else $error("read data not taken at strobe rise");
    a_sync_sample: assert property (@(posedge clk) disable iff (!rst_n)
        tick && phase_ff == ebc_ready_pkg::PH_ACCESS && last && rdy_en_ff
        && !async_ff && ready_in == pol_ff
        |=> phase_ff != ebc_ready_pkg::PH_RDYWAIT ##1 rd_n_ff && wr_n_ff)
        else $error("sync ready seen active not honoured");
    a_done_idle: assert property (@(posedge clk) disable iff (!rst_n)
        done_ff |-> phase_ff == ebc_ready_pkg::PH_IDLE && rd_n_ff && wr_n_ff
        ##1 !done_ff)
        else $error("done pulse outside idle");
endmodule : external_bus_ready_waitstate
`default_nettype wire

// [src/dummy_never.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [bench/ready_partner.sv]
`timescale 1ns/100ps
`default_nettype none
module ready_partner (
    input wire logic ref_clk,
    input wire logic link_clk,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic async_mode,
    input wire logic active_high,
    input wire logic [3:0] delay,
    input wire logic [15:0] word,
    output logic ready_in,
    output logic [15:0] data_in
);
    logic strobe;
    logic rdy_act = 1'b0;
    logic [3:0] seen = 4'h0;

    assign strobe = !rd_n || !wr_n;
    // Inactive level is the inverse of the chosen polarity
    assign ready_in = rdy_act ? active_high : !active_high;
    // Read word while selected, scrambled once released
    assign #1 data_in = rd_n ? ~word : word;

    task automatic step();
        if (strobe) begin
            if (seen >= delay) begin
                rdy_act = 1'b1;
            end else begin
                seen = seen + 4'h1;
            end
        end
    endtask : step

    // Synchronous mode follows the reference clock's falling edge
    always @(negedge ref_clk) begin
        #2;
        if (!async_mode) step();
    end
    // Asynchronous mode runs on the partner's own clock
    always @(posedge link_clk) begin
        if (async_mode) step();
    end
    // Withdraw ready on the strobe's trailing edge
    always @(negedge strobe) begin
        rdy_act = 1'b0;
        seen = 4'h0;
    end
endmodule : ready_partner
`default_nettype wire

// [bench/external_bus_ready_waitstate_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module external_bus_ready_waitstate_bench;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic write = 1'b0;
    logic [ebc_ready_pkg::ADDR_W-1:0] addr = 24'h00_0000;
    logic [ebc_ready_pkg::DATA_W-1:0] wdata = 16'h0000;
    logic [ebc_ready_pkg::E_W-1:0] e_len = 6'h01;
    logic ready_enable = 1'b1;
    logic ready_active_high = 1'b1;
    logic ready_async = 1'b0;
    logic [3:0] p_delay = 4'h0;
    logic [15:0] p_word = 16'h0000;
    logic busy, done, rd_n, wr_n, data_oe, ref_clk, ready_in;
    logic [15:0] rdata, data_in, data_out;
    logic [7:0] wait_states, got_waits;
    logic [23:0] bus_addr;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 clk = ~clk;
    always #62.5 link_clk = ~link_clk;

    external_bus_ready_waitstate dut (
        .clk(clk), .rst_n(rst_n), .start(start), .write(write),
        .addr(addr), .wdata(wdata), .addr_phase_length(3'h1),
        .cmd_phase_length(2'h0), .setup_phase_length(1'h0),
        .access_phase_length(e_len), .hold_phase_length(2'h0),
        .ready_enable(ready_enable), .ready_active_high(ready_active_high),
        .ready_async(ready_async), .busy(busy), .done(done),
        .rdata(rdata), .wait_states(wait_states),
        .bus_reference_clock_output(ref_clk), .bus_addr(bus_addr),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .ready_in(ready_in)
    );

    ready_partner partner (
        .ref_clk(ref_clk), .link_clk(link_clk), .rd_n(rd_n), .wr_n(wr_n),
        .async_mode(ready_async), .active_high(ready_active_high),
        .delay(p_delay), .word(p_word), .ready_in(ready_in),
        .data_in(data_in)
    );

    task automatic summarize();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    // One bus cycle; poke tries a second start while busy
    task automatic do_cycle(input logic wr, input logic [23:0] a,
            input logic [15:0] w, input bit poke);
        int k;
        bit bad_w;
        k = 0;
        bad_w = 0;
        @(negedge clk);
        write = wr;
        addr = a;
        wdata = w;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        @(negedge clk);
        check(busy === 1'b1, "busy not raised");
        while (done !== 1'b1 && k < 600) begin
            start = poke && k == 3;
            addr = (poke && k == 3) ? 24'h00_0bad : a;
            if (wr_n === 1'b0 && (data_out !== w || data_oe !== 1'b1)) begin
                bad_w = 1;
            end
            @(negedge clk);
            k++;
        end
        start = 1'b0;
        check(done === 1'b1, "no done");
        check(!bad_w, "write data not driven");
        check(bus_addr === a, "address");
        got_waits = wait_states;
    endtask : do_cycle

    task automatic t_sync_waits();
        for (int d = 0; d < 4; d++) begin
            p_delay = d[3:0];
            p_word = 16'h5a00 + 16'(d);
            do_cycle(1'b0, 24'h00_1230, 16'h0000, 0);
            check(got_waits === 8'(d), "sync wait count");
            check(rdata === p_word, "read data");
        end
        $display("sync waits test done");
    endtask : t_sync_waits

    task automatic t_polarity();
        for (int p = 0; p < 2; p++) begin
            ready_active_high = p[0];
            p_delay = 4'h2;
            do_cycle(1'b0, 24'h00_4000, 16'h0000, 0);
            check(got_waits === 8'h02, "polarity wait count");
        end
        ready_active_high = 1'b1;
        $display("polarity test done");
    endtask : t_polarity

    task automatic t_access_mask();
        logic [3:0] dl [3] = '{4'h1, 4'h3, 4'h3};
        logic [5:0] el [3] = '{6'h04, 6'h02, 6'h03};
        logic [7:0] wx [3] = '{8'h00, 8'h02, 8'h01};
        for (int i = 0; i < 3; i++) begin
            p_delay = dl[i];
            e_len = el[i];
            do_cycle(1'b0, 24'h00_0010, 16'h0000, 0);
            check(got_waits === wx[i], "access phase masking");
        end
        e_len = 6'h01;
        $display("access mask test done");
    endtask : t_access_mask

    task automatic t_async();
        ready_async = 1'b1;
        p_delay = 4'h0;
        p_word = 16'hc3a5;
        do_cycle(1'b0, 24'h00_2000, 16'h0000, 0);
        check(got_waits >= 8'h01, "async adds wait");
        check(got_waits < 8'h28, "async too slow");
        check(rdata === 16'hc3a5, "async read data");
        ready_async = 1'b0;
        $display("async test done");
    endtask : t_async

    task automatic t_write();
        p_delay = 4'h1;
        do_cycle(1'b1, 24'h12_3456, 16'hbeef, 0);
        check(got_waits === 8'h01, "write wait count");
        check(wr_n === 1'b1 && data_oe === 1'b0, "write end");
        $display("write test done");
    endtask : t_write

    task automatic t_no_ready();
        ready_enable = 1'b0;
        p_delay = 4'h5;
        e_len = 6'h02;
        do_cycle(1'b0, 24'h00_0020, 16'h0000, 0);
        check(got_waits === 8'h00, "ready not ignored");
        ready_enable = 1'b1;
        e_len = 6'h01;
        $display("no ready test done");
    endtask : t_no_ready

    task automatic t_refuse();
        logic rc;
        p_delay = 4'h3;
        do_cycle(1'b0, 24'h00_0777, 16'h0000, 1);
        repeat (10) @(negedge clk);
        check(busy === 1'b0 && bus_addr === 24'h00_0777, "start refused");
        rc = ref_clk;
        @(negedge clk);
        check(ref_clk === !rc, "reference clock not toggling");
        $display("refuse test done");
    endtask : t_refuse

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        check(rd_n === 1'b1 && wr_n === 1'b1 && busy === 1'b0, "reset");
        rst_n = 1'b1;
        t_sync_waits();
        t_polarity();
        t_access_mask();
        t_async();
        t_write();
        t_no_ready();
        t_refuse();
        summarize();
    end
endmodule : external_bus_ready_waitstate_bench
`default_nettype wire
